// *** logic/rbcs_pkg.sv ***
//////////////////////////////////////////////////////////////////////////////
// Contract
// - Force pin set at reset enters serial loader; selector 00 serial-character, 01 CAN.
// - Force pin clear starts a flash search for a valid signature first.
// - No valid location found enters static low-power mode with processor waiting.
// - Search runs after power-on, external, internal reset; skipped after software reset.
// - Eight fixed locations probed in order, first 16K through last 256K block.
// - Config half word is upper 16 bits of first word; vector is next word.
// - After applying config bits, execution goes to the stored boot vector.
// - Location valid when half word carries signature; code bit lies inside it.
// - Debugger bypass applies no configuration half word.
//////////////////////////////////////////////////////////////////////////////
package rbcs_pkg;

  localparam int          ADDR_W      = 32;
  localparam int          NUM_LOC     = 8;
  localparam logic [31:0] LOC_ADDR [NUM_LOC] = '{
    32'h00f9_8000, 32'h00f9_c000, 32'h00fa_0000, 32'h00fb_0000,
    32'h0100_0000, 32'h0104_0000, 32'h0108_0000, 32'h010c_0000};
  localparam logic [31:0] VEC_OFFSET  = 32'h0000_0004;
  // Signature bits of the half word, code bit excluded from the compare
  localparam logic [15:0] SIG_MASK    = 16'hfeff;
  localparam logic [15:0] SIG_VALUE   = 16'h005a;
  localparam int          HW_MSB      = 31;
  localparam int          HW_LSB      = 16;
  localparam int          CODE_BIT    = 8;
  localparam logic [1:0]  SEL_SCI     = 2'h0;
  localparam logic [1:0]  SEL_CAN     = 2'h1;

  typedef enum logic [1:0] {
    BOOT_NONE,
    BOOT_SCI,
    BOOT_CAN,
    BOOT_FLASH
  } rbcs_boot_t;

  typedef enum logic [2:0] {
    RESET_POR,
    RESET_EXT,
    RESET_INT,
    RESET_SW,
    RESET_DBG
  } rbcs_cause_t;

endpackage : rbcs_pkg

// *** logic/rbcs_flash_port.sv ***
`timescale 1ns/1ps
// Registered read port toward the flash array
module rbcs_flash_port #(
  parameter int ADDR_W = 32
) (
  // Clock and reset
  input  wire logic              clk_sys,
  input  wire logic              rst,
  input  wire logic              clkEn,
  // Request from the search engine
  input  wire logic              reqValid,
  input  wire logic [ADDR_W-1:0] reqAddr,
  // Array side
  output logic                   flashRd,
  output logic [ADDR_W-1:0]      flashAddr,
  input  wire logic              flashAck,
  input  wire logic [31:0]       flashData,
  // Answer
  output logic                   rspValid,
  output logic [31:0]            rspData
);

  logic              rdD;
  logic [ADDR_W-1:0] addrD;
  logic              rspD;
  logic [31:0]       dataD;

  always_comb
  begin
    rdD   = flashRd;
    addrD = flashAddr;
    rspD  = 1'b0;
    dataD = rspData;
    if (reqValid)
    begin
      rdD   = 1'b1;
      addrD = reqAddr;
    end
    else if (flashRd && flashAck)
    begin
      rdD   = 1'b0;
      rspD  = 1'b1;
      dataD = flashData;
    end
  end

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      flashRd   <= 1'b0;
      flashAddr <= '0;
      rspValid  <= 1'b0;
      rspData   <= 32'h0000_0000;
    end
    else if (clkEn)
    begin
      flashRd   <= rdD;
      flashAddr <= addrD;
      rspValid  <= rspD;
      rspData   <= dataD;
    end
  end

endmodule : rbcs_flash_port

// *** logic/rbcs_boot_search.sv ***
`timescale 1ns/1ps
module rbcs_boot_search #(
  parameter int ADDR_W  = rbcs_pkg::ADDR_W,
  parameter int NUM_LOC = rbcs_pkg::NUM_LOC
) (
  // Clock and reset
  input  wire logic                 clk_sys,
  input  wire logic                 rst,
  input  wire logic                 clkEn,
  // Reset sequence
  input  wire logic                 bootStart,
  input  wire rbcs_pkg::rbcs_cause_t resetCause,
  // Strap pins
  input  wire logic                 forceAltBootPin,
  input  wire logic [1:0]           altBootSelectPins,
  // Flash array
  output logic                      flashRd,
  output logic [ADDR_W-1:0]         flashAddr,
  input  wire logic                 flashAck,
  input  wire logic [31:0]          flashData,
  // Core side
  output logic                      bootDone,
  output rbcs_pkg::rbcs_boot_t      bootMode,
  output logic                      staticMode,
  output logic                      cfgApply,
  output logic [15:0]               resetConfigHalfword,
  output logic                      variableLengthCodeBit,
  output logic [ADDR_W-1:0]         bootVector,
  output logic                      coreStart
);

  typedef enum logic [2:0] {
    ST_IDLE, ST_RD_CFG, ST_WAIT_CFG, ST_RD_VEC, ST_WAIT_VEC, ST_DONE
  } rbcs_state_t;

  function automatic logic sigOk(input logic [15:0] hw);
    sigOk = (hw & rbcs_pkg::SIG_MASK) == rbcs_pkg::SIG_VALUE;
  endfunction : sigOk

  rbcs_state_t          stateQ, stateD;
  logic [2:0]           idxQ, idxD;
  logic                 reqValid;
  logic [ADDR_W-1:0]    reqAddr;
  logic                 rspValid;
  logic [31:0]          rspData;
  logic                 doneD, staticD, applyD, startD;
  rbcs_pkg::rbcs_boot_t modeD;
  logic [15:0]          hwD;
  logic [ADDR_W-1:0]    vecD;

  rbcs_flash_port #(.ADDR_W(ADDR_W)) rbcs_flash_port_inst (
    .clk_sys   (clk_sys),
    .rst       (rst),
    .clkEn     (clkEn),
    .reqValid  (reqValid),
    .reqAddr   (reqAddr),
    .flashRd   (flashRd),
    .flashAddr (flashAddr),
    .flashAck  (flashAck),
    .flashData (flashData),
    .rspValid  (rspValid),
    .rspData   (rspData)
  );

  //////////////////////////////////////////////////////////////////////////////
  always_comb
  begin
    stateD   = stateQ;
    idxD     = idxQ;
    reqValid = 1'b0;
    reqAddr  = rbcs_pkg::LOC_ADDR[idxQ][ADDR_W-1:0];
    doneD    = bootDone;
    modeD    = bootMode;
    staticD  = staticMode;
    applyD   = 1'b0;
    startD   = 1'b0;
    hwD      = resetConfigHalfword;
    vecD     = bootVector;
    case (stateQ)
      ST_IDLE:
      begin
        if (bootStart)
        begin
          idxD = 3'h0;
          if (forceAltBootPin)
          begin
            modeD  = (altBootSelectPins == rbcs_pkg::SEL_CAN) ? rbcs_pkg::BOOT_CAN : rbcs_pkg::BOOT_SCI;
            doneD  = 1'b1;
            startD = 1'b1;
            stateD = ST_DONE;
          end
          else if (resetCause == rbcs_pkg::RESET_SW || resetCause == rbcs_pkg::RESET_DBG)
          begin
            modeD  = rbcs_pkg::BOOT_NONE;
            doneD  = 1'b1;
            startD = 1'b1;
            stateD = ST_DONE;
          end
          else
          begin
            stateD = ST_RD_CFG;
          end
        end
      end
      ST_RD_CFG:
      begin
        reqValid = 1'b1;
        stateD   = ST_WAIT_CFG;
      end
      ST_WAIT_CFG:
      begin
        if (rspValid)
        begin
          if (sigOk(rspData[rbcs_pkg::HW_MSB:rbcs_pkg::HW_LSB]))
          begin
            hwD    = rspData[rbcs_pkg::HW_MSB:rbcs_pkg::HW_LSB];
            stateD = ST_RD_VEC;
          end
          else if (idxQ == 3'(NUM_LOC - 1))
          begin
            modeD   = rbcs_pkg::BOOT_NONE;
            staticD = 1'b1;
            doneD   = 1'b1;
            stateD  = ST_DONE;
          end
          else
          begin
            idxD   = idxQ + 3'h1;
            stateD = ST_RD_CFG;
          end
        end
      end
      ST_RD_VEC:
      begin
        reqValid = 1'b1;
        reqAddr  = rbcs_pkg::LOC_ADDR[idxQ][ADDR_W-1:0] + rbcs_pkg::VEC_OFFSET[ADDR_W-1:0];
        stateD   = ST_WAIT_VEC;
      end
      ST_WAIT_VEC:
      begin
        if (rspValid)
        begin
          vecD   = rspData[ADDR_W-1:0];
          applyD = 1'b1;
          startD = 1'b1;
          modeD  = rbcs_pkg::BOOT_FLASH;
          doneD  = 1'b1;
          stateD = ST_DONE;
        end
      end
      ST_DONE:
      begin
        stateD = ST_DONE;
      end
      default:
      begin
        stateD = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      stateQ                <= ST_IDLE;
      idxQ                  <= 3'h0;
      bootDone              <= 1'b0;
      bootMode              <= rbcs_pkg::BOOT_NONE;
      staticMode            <= 1'b0;
      cfgApply              <= 1'b0;
      resetConfigHalfword   <= 16'h0000;
      variableLengthCodeBit <= 1'b0;
      bootVector            <= '0;
      coreStart             <= 1'b0;
    end
    else if (clkEn)
    begin
      stateQ                <= stateD;
      idxQ                  <= idxD;
      bootDone              <= doneD;
      bootMode              <= modeD;
      staticMode            <= staticD;
      cfgApply              <= applyD;
      resetConfigHalfword   <= hwD;
      variableLengthCodeBit <= hwD[rbcs_pkg::CODE_BIT];
      bootVector            <= vecD;
      coreStart             <= startD;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  alt_boot_mode_a: assert property (clkEn && stateQ == ST_IDLE && bootStart && forceAltBootPin
    |=> bootMode != rbcs_pkg::BOOT_FLASH && bootMode != rbcs_pkg::BOOT_NONE && coreStart)
    else $error("alternate boot not entered");
  sw_skip_a: assert property (clkEn && stateQ == ST_IDLE && bootStart && !forceAltBootPin
    && resetCause == rbcs_pkg::RESET_SW |=> !flashRd && bootDone)
    else $error("search ran after software reset");
  search_start_a: assert property ((clkEn && stateQ == ST_IDLE && bootStart && !forceAltBootPin
    && resetCause == rbcs_pkg::RESET_POR) ##1 clkEn |=> flashRd)
    else $error("search not started");
  first_loc_a: assert property ($rose(flashRd) && $past(stateQ) == ST_RD_CFG && idxQ == 3'h0
    |-> flashAddr == rbcs_pkg::LOC_ADDR[0][ADDR_W-1:0])
    else $error("first probe address wrong");
  static_entry_a: assert property ($rose(staticMode) |-> bootDone && !coreStart && !cfgApply)
    else $error("static mode entered wrongly");
  apply_sig_a: assert property (cfgApply |-> sigOk(resetConfigHalfword) && coreStart
    && bootMode == rbcs_pkg::BOOT_FLASH)
    else $error("applied half word without signature");
  code_bit_a: assert property (clkEn && stateQ == ST_WAIT_CFG && rspValid
    && sigOk(rspData[rbcs_pkg::HW_MSB:rbcs_pkg::HW_LSB])
    |=> variableLengthCodeBit == $past(rspData[rbcs_pkg::HW_LSB + rbcs_pkg::CODE_BIT]))
    else $error("code bit mismatch");
  vec_next_a: assert property (flashRd && stateQ == ST_WAIT_VEC |-> flashAddr
    == rbcs_pkg::LOC_ADDR[idxQ][ADDR_W-1:0] + rbcs_pkg::VEC_OFFSET[ADDR_W-1:0])
    else $error("vector not read beside half word");
  no_apply_dbg_a: assert property (bootDone && bootMode != rbcs_pkg::BOOT_FLASH |-> !cfgApply)
    else $error("config applied outside flash boot");
  stop_first_a: assert property (stateQ == ST_RD_VEC |=> $stable(idxQ) [*2])
    else $error("search continued past valid location");

  flash_boot_c: cover property (cfgApply);
  static_c: cover property ($rose(staticMode));
  can_boot_c: cover property (bootMode == rbcs_pkg::BOOT_CAN);
  last_loc_c: cover property (idxQ == 3'h7 && rspValid);

endmodule : rbcs_boot_search

// *** testbench/rbcs_flash_model.sv ***
`timescale 1ns/1ps
// Flash array behind the read port
module rbcs_flash_model (
  // Clock
  input  wire logic        clk_sys,
  // Read port
  input  wire logic        flashRd,
  input  wire logic [31:0] flashAddr,
  output logic             flashAck,
  output logic [31:0]      flashData,
  // Content and answer delay
  input  wire logic [7:0]  validMask,
  input  wire logic        codeBit,
  input  wire logic [3:0]  waitCycles
);
  logic [3:0] cnt;

  function automatic logic [31:0] lookup(logic [31:0] a);
    for (int i = 0; i < 8; i++)
    begin
      if (a == rbcs_pkg::LOC_ADDR[i])
        return validMask[i] ? {(codeBit ? 16'h015a : 16'h005a), 16'h0000} : 32'h015b_0000;
      if (a == rbcs_pkg::LOC_ADDR[i] + 32'h4)
        return 32'h4000_0000 | (32'(i) << 8);
    end
    return ~flashData;
  endfunction : lookup

  initial
  begin
    flashAck = 1'b0;
    flashData = 32'h0;
    cnt = 4'h0;
  end

  // Data never holds outside the answer cycle
  always @(posedge clk_sys)
  begin
    flashData <= ~flashData;
    flashAck <= 1'b0;
    if (flashRd && !flashAck)
    begin
      cnt <= cnt + 4'h1;
      if (cnt >= waitCycles)
      begin
        flashAck <= 1'b1;
        flashData <= lookup(flashAddr);
        cnt <= 4'h0;
      end
    end
  end
endmodule : rbcs_flash_model

// *** testbench/rbcs_boot_search_bench.sv ***
`timescale 1ns/1ps
module rbcs_boot_search_bench;
  typedef struct {
    rbcs_pkg::rbcs_cause_t cause;
    logic forceAlt;
    logic [1:0] sel;
    logic [7:0] mask;
    logic cb;
    logic [3:0] wt;
    rbcs_pkg::rbcs_boot_t mode;
  } rbcs_row_t;

  logic clk_sys, rst, clkEn, bootStart, forceAlt, flashRd, flashAck, cb;
  logic bootDone, staticMode, cfgApply, codeOut, coreStart;
  logic [1:0] sel;
  logic [7:0] mask;
  logic [3:0] wt;
  logic [15:0] hw;
  logic [31:0] flashAddr, flashData, bootVector;
  rbcs_pkg::rbcs_cause_t cause;
  rbcs_pkg::rbcs_boot_t bootMode;
  int errors, nChecks, nProbe, nStart, nApply;
  rbcs_row_t rows [9];

  rbcs_boot_search rbcs_boot_search_inst (.clk_sys(clk_sys), .rst(rst), .clkEn(clkEn), .bootStart(bootStart),
    .resetCause(cause), .forceAltBootPin(forceAlt), .altBootSelectPins(sel), .flashRd(flashRd),
    .flashAddr(flashAddr),
    .flashAck(flashAck), .flashData(flashData), .bootDone(bootDone), .bootMode(bootMode), .staticMode(staticMode),
    .cfgApply(cfgApply), .resetConfigHalfword(hw), .variableLengthCodeBit(codeOut), .bootVector(bootVector),
    .coreStart(coreStart));
  rbcs_flash_model rbcs_flash_model_inst (.clk_sys(clk_sys), .flashRd(flashRd), .flashAddr(flashAddr),
    .flashAck(flashAck), .flashData(flashData), .validMask(mask), .codeBit(cb), .waitCycles(wt));

  initial
  begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end

  task automatic check(string name, logic [31:0] seen, logic [31:0] exp);
    nChecks++;
    if (seen !== exp)
    begin
      errors++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic end_sim();
    $display("checks %0d errors %0d", nChecks, errors);
    if (errors == 0 && nChecks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : end_sim

  task automatic wait_done();
    for (int k = 0; k < 400 && bootDone !== 1'b1; k++)
      @(negedge clk_sys);
    check("bootDone", bootDone, 1);
  endtask : wait_done

  // Probe order, start and apply pulses
  always @(negedge clk_sys)
    if (!rst)
    begin
      if (flashRd && flashAck && !flashAddr[2])
      begin
        if (nProbe < 8)
          check("probeAddr", flashAddr, rbcs_pkg::LOC_ADDR[nProbe]);
        nProbe++;
      end
      nStart += (coreStart === 1'b1);
      nApply += (cfgApply === 1'b1);
    end

  task automatic run_row(input rbcs_row_t r);
    int first;
    logic skip;
    logic stat;
    first = 8;
    for (int i = 7; i >= 0; i--)
      if (r.mask[i])
        first = i;
    skip = r.forceAlt || r.cause == rbcs_pkg::RESET_SW || r.cause == rbcs_pkg::RESET_DBG;
    stat = !skip && first == 8;
    rst = 1'b1;
    {nProbe, nStart, nApply} = '0;
    cause = r.cause;
    {forceAlt, sel, mask, cb, wt} = {r.forceAlt, r.sel, r.mask, r.cb, r.wt};
    repeat (8) @(negedge clk_sys);
    rst = 1'b0;
    bootStart = 1'b1;
    @(negedge clk_sys);
    bootStart = 1'b0;
    wait_done();
    // A second request after the decision is ignored
    @(negedge clk_sys);
    bootStart = 1'b1;
    @(negedge clk_sys);
    bootStart = 1'b0;
    repeat (20) @(negedge clk_sys);
    check("bootMode", bootMode, r.mode);
    check("staticMode", staticMode, stat);
    check("searched", nProbe != 0, !skip);
    check("probes", nProbe, skip ? 0 : (stat ? 8 : first + 1));
    check("coreStart", nStart, stat ? 0 : 1);
    check("cfgApply", nApply, !skip && !stat);
    if (!skip && !stat)
    begin
      check("bootVector", bootVector, 32'h4000_0000 | (first << 8));
      check("halfword", hw, r.cb ? 16'h015a : 16'h005a);
      check("codeBit", codeOut, r.cb);
    end
  endtask : run_row

  initial
  begin
    {rst, clkEn, bootStart, forceAlt, sel, mask, cb, wt} = {1'b1, 1'b1, 1'b0, 1'b0, 2'h0, 8'h00, 1'b0, 4'h0};
    {errors, nChecks, nProbe, nStart, nApply} = '0;
    cause = rbcs_pkg::RESET_POR;
    rows = '{
      '{rbcs_pkg::RESET_POR, 1'b1, 2'h0, 8'hff, 1'b0, 4'h0, rbcs_pkg::BOOT_SCI},
      '{rbcs_pkg::RESET_EXT, 1'b1, 2'h1, 8'h00, 1'b0, 4'h0, rbcs_pkg::BOOT_CAN},
      '{rbcs_pkg::RESET_INT, 1'b1, 2'h2, 8'h00, 1'b0, 4'h0, rbcs_pkg::BOOT_SCI},
      '{rbcs_pkg::RESET_POR, 1'b0, 2'h0, 8'h01, 1'b1, 4'h0, rbcs_pkg::BOOT_FLASH},
      '{rbcs_pkg::RESET_EXT, 1'b0, 2'h0, 8'h80, 1'b0, 4'h3, rbcs_pkg::BOOT_FLASH},
      '{rbcs_pkg::RESET_INT, 1'b0, 2'h0, 8'h24, 1'b1, 4'h0, rbcs_pkg::BOOT_FLASH},
      '{rbcs_pkg::RESET_POR, 1'b0, 2'h0, 8'h00, 1'b0, 4'h1, rbcs_pkg::BOOT_NONE},
      '{rbcs_pkg::RESET_SW, 1'b0, 2'h0, 8'hff, 1'b0, 4'h0, rbcs_pkg::BOOT_NONE},
      '{rbcs_pkg::RESET_DBG, 1'b0, 2'h0, 8'hff, 1'b0, 4'h0, rbcs_pkg::BOOT_NONE}};
    @(negedge clk_sys);
    foreach (rows[r])
      run_row(rows[r]);
    // Reset state, then a request held while the clock enable is low
    rst = 1'b1;
    cause = rbcs_pkg::RESET_POR;
    {forceAlt, mask} = {1'b0, 8'h02};
    repeat (8) @(negedge clk_sys);
    check("resetOut", {bootDone, staticMode, cfgApply, coreStart, bootMode}, 0);
    rst = 1'b0;
    clkEn = 1'b0;
    bootStart = 1'b1;
    repeat (10) @(negedge clk_sys);
    check("frozen", {flashRd, bootDone}, 0);
    clkEn = 1'b1;
    @(negedge clk_sys);
    bootStart = 1'b0;
    wait_done();
    check("frozenVector", bootVector, 32'h4000_0100);
    end_sim();
  end

  initial
  begin
    #80000;
    errors++;
    end_sim();
  end
endmodule : rbcs_boot_search_bench
